// File: ufic_far.sv
// far side model: receive and transmit shift registers
module ufic_far (
	// clock
	input wire logic ref_clk,
	// transmit side
	input wire logic tx_valid,
	input wire logic [7:0] tx_data_reg,
	output logic tx_ready,
	// receive side
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic [2:0] rx_err,
	// slow answer when high
	input wire logic stall
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cap [0:7];
	int n_cap = 0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_err = 3'h0;
	end
	// ready one cycle late, so the lagging head byte has settled
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready) begin
			cap[n_cap[2:0]] <= tx_data_reg;
			n_cap <= n_cap + 1;
		end
		tx_ready <= tx_valid && !tx_ready && !stall;
	end
	// idle data is inverted so a stale byte is never taken
	task automatic send(input logic [7:0] b, input logic [2:0] e);
		@(posedge ref_clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_err <= e;
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		rx_err <= 3'h0;
	endtask
endmodule

// File: ufic_fifo.v
// sixteen-entry byte fifo with flush
`include "ufic_map.vh"
module ufic_fifo (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	input wire ce,
	// control
	input wire flush,
	input wire push,
	input wire [7:0] push_data,
	input wire pop,
	// state
	output wire [7:0] head_data,
	output reg [4:0] count_reg
);
	reg [7:0] mem_reg [0:15];
	reg [3:0] wr_ptr_reg;
	reg [3:0] rd_ptr_reg;
	wire do_push;
	wire do_pop;
	integer i;

	assign do_pop = pop && (count_reg != 5'h00);
	assign do_push = push && (count_reg != `UFIC_DEPTH || do_pop);
	assign head_data = mem_reg[rd_ptr_reg];

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			count_reg <= 5'h00;
			for (i = 0; i < 16; i = i + 1) begin
				mem_reg[i] <= 8'h00;
			end
		end else if (ce) begin
			if (flush) begin
				wr_ptr_reg <= 4'h0;
				rd_ptr_reg <= 4'h0;
				count_reg <= 5'h00;
			end else begin
				if (do_push) begin
					mem_reg[wr_ptr_reg] <= push_data;
					wr_ptr_reg <= wr_ptr_reg + 4'h1;
				end
				if (do_pop) begin
					rd_ptr_reg <= rd_ptr_reg + 4'h1;
				end
				if (do_push && !do_pop) begin
					count_reg <= count_reg + 5'h01;
				end else if (do_pop && !do_push) begin
					count_reg <= count_reg - 5'h01;
				end
			end
		end
	end
endmodule

// File: ufic_map.vh
// register map, field layout and codes of the uart fifo/interrupt block
`ifndef UFIC_MAP_VH
`define UFIC_MAP_VH
`define UFIC_OFS_DATA 3'h0
`define UFIC_OFS_IEN 3'h1
`define UFIC_OFS_IID 3'h2
`define UFIC_OFS_LFC 3'h3
`define UFIC_OFS_MCTL 3'h4
`define UFIC_OFS_LSTAT 3'h5
`define UFIC_OFS_MSTAT 3'h6
`define UFIC_OFS_SCR 3'h7
`define UFIC_FC_EN 0
`define UFIC_FC_RXCLR 1
`define UFIC_FC_TXCLR 2
`define UFIC_FC_DMA 3
`define UFIC_LFC_DLS 7
`define UFIC_LFC_STOP 2
`define UFIC_LFC_PEN 3
`define UFIC_MC_AUX2 3
`define UFIC_IE_RDA 0
`define UFIC_IE_THRE 1
`define UFIC_IE_RLS 2
`define UFIC_IE_MS 3
`define UFIC_ID_NONE 4'h1
`define UFIC_ID_RLS 4'h6
`define UFIC_ID_RDA 4'h4
`define UFIC_ID_CTO 4'hc
`define UFIC_ID_THRE 4'h2
`define UFIC_ID_MS 4'h0
`define UFIC_TRIG_1 5'h01
`define UFIC_TRIG_4 5'h04
`define UFIC_TRIG_8 5'h08
`define UFIC_TRIG_14 5'h0e
`define UFIC_DEPTH 5'h10
`define UFIC_ONE_BYTE 5'h01
`define UFIC_OVERSAMPLE 4'hf
`define UFIC_TO_CHARS 6'h04
`define UFIC_WORD_BASE 4'h5
`define UFIC_DIV_RESET 16'h0001
`define UFIC_PINS_IDLE 4'hf
`endif

// File: ufic_timeout.v
// four-character idle detector for the receive fifo
`include "ufic_map.vh"
module ufic_timeout (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	input wire ce,
	// conditions
	input wire armed,
	input wire activity,
	input wire [15:0] divisor,
	input wire [7:0] line_format,
	// result
	output reg expired_reg
);
	reg [15:0] pre_reg;
	reg [3:0] os_reg;
	reg [9:0] bits_reg;
	wire [3:0] frame_bits;
	wire [9:0] limit;
	wire [15:0] div_eff;

	// frame: start + data + parity + stop
	assign frame_bits = 4'h1 + `UFIC_WORD_BASE + {2'h0, line_format[1:0]} +
		{3'h0, line_format[`UFIC_LFC_PEN]} + 4'h1 +
		{3'h0, line_format[`UFIC_LFC_STOP]};
	assign limit = {6'h00, frame_bits} * {4'h0, `UFIC_TO_CHARS};
	// divisor zero is treated as one
	assign div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor;

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pre_reg <= 16'h0000;
			os_reg <= 4'h0;
			bits_reg <= 10'h000;
			expired_reg <= 1'b0;
		end else if (ce) begin
			// restart on push, pop or empty
			if (!armed || activity) begin
				pre_reg <= 16'h0000;
				os_reg <= 4'h0;
				bits_reg <= 10'h000;
				expired_reg <= 1'b0;
			end else if (!expired_reg) begin
				if (pre_reg == div_eff - 16'h0001) begin
					pre_reg <= 16'h0000;
					os_reg <= os_reg + 4'h1;
					if (os_reg == `UFIC_OVERSAMPLE) begin
						bits_reg <= bits_reg + 10'h001;
						if (bits_reg == limit - 10'h001) begin
							expired_reg <= 1'b1;
						end
					end
				end else begin
					pre_reg <= pre_reg + 16'h0001;
				end
			end
		end
	end
endmodule

// File: ufic_top.v
// uart interrupt identification and fifo control
`include "ufic_map.vh"
module ufic_top (
	// clock and reset
	input wire ref_clk,
	input wire sys_rst,
	input wire ce,
	// host register port
	input wire [2:0] host_addr,
	input wire host_rd,
	input wire host_wr,
	input wire [7:0] host_wdata,
	output reg [7:0] host_rdata_reg,
	// receive shift register side
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire rx_parity_err,
	input wire rx_framing_err,
	input wire rx_break,
	// transmit shift register side
	output wire tx_valid,
	output reg [7:0] tx_data_reg,
	input wire tx_ready,
	// modem pins
	input wire cts_n,
	input wire dsr_n,
	input wire ri_n,
	input wire dcd_n,
	// format and interrupt
	output wire [7:0] line_format,
	output wire [15:0] baud_divisor,
	output wire irq,
	output wire irq_oe_n
);
	reg [7:0] lfc_reg;
	reg [7:0] ien_reg;
	reg [7:0] mctl_reg;
	reg [7:0] scr_reg;
	reg [15:0] div_reg;
	reg fifo_en_reg;
	reg [1:0] trig_sel_reg;
	reg dma_sel_reg;
	reg [3:0] oe_pe_fe_bi_reg;
	reg thre_pend_reg;
	reg ms_pend_reg;
	reg [3:0] dmodem_reg;
	reg [3:0] modem_s1_reg;
	reg [3:0] modem_s2_reg;
	reg [3:0] modem_q_reg;
	reg [3:0] iid_reg;
	reg rd_q_reg;
	reg [3:0] id_next;
	reg [4:0] trig_level;
	reg [7:0] rd_mux;
	wire rd_start;
	wire iid_access;
	wire wr_data, wr_fc, rd_data, rd_lstat, rd_mstat, rd_iid;
	wire divisor_latch_select;
	wire [4:0] rx_count, tx_count;
	wire [7:0] rx_head, tx_head;
	wire rx_full, tx_full, rx_push, rx_pop, tx_push, tx_pop;
	wire rx_flush, tx_flush, overrun;
	wire timeout;
	wire rls_int, rda_int, cto_int, thre_int, ms_int;
	wire [3:0] modem_now;

	assign divisor_latch_select = lfc_reg[`UFIC_LFC_DLS];
	assign line_format = lfc_reg;
	assign baud_divisor = div_reg;
	assign rd_start = host_rd && !rd_q_reg;
	assign iid_access = host_rd && host_addr == `UFIC_OFS_IID;
	assign wr_data = host_wr && host_addr == `UFIC_OFS_DATA && !divisor_latch_select;
	// fifo control decoded on writes only
	assign wr_fc = host_wr && host_addr == `UFIC_OFS_IID;
	assign rd_data = rd_start && host_addr == `UFIC_OFS_DATA && !divisor_latch_select;
	assign rd_iid = rd_start && host_addr == `UFIC_OFS_IID;
	assign rd_lstat = rd_start && host_addr == `UFIC_OFS_LSTAT;
	assign rd_mstat = rd_start && host_addr == `UFIC_OFS_MSTAT;

	assign rx_flush = (wr_fc && (!host_wdata[`UFIC_FC_EN] ||
		host_wdata[`UFIC_FC_RXCLR])) || !fifo_en_reg;
	assign tx_flush = (wr_fc && (!host_wdata[`UFIC_FC_EN] ||
		host_wdata[`UFIC_FC_TXCLR])) || !fifo_en_reg;

	// non-fifo mode keeps a single holding byte per direction outside the fifos
	reg [7:0] rx_hold_reg;
	reg rx_hold_full_reg;
	reg tx_hold_full_reg;
	reg [7:0] tx_hold_reg;

	assign rx_full = fifo_en_reg ? (rx_count == `UFIC_DEPTH) :
		rx_hold_full_reg;
	assign tx_full = fifo_en_reg ? (tx_count == `UFIC_DEPTH) :
		tx_hold_full_reg;
	assign overrun = rx_valid && rx_full && !rx_pop;
	assign rx_push = rx_valid && fifo_en_reg;
	assign rx_pop = rd_data && fifo_en_reg;
	assign tx_push = wr_data && fifo_en_reg;
	assign tx_valid = fifo_en_reg ? (tx_count != 5'h00) :
		tx_hold_full_reg;
	assign tx_pop = tx_valid && tx_ready && fifo_en_reg;

	ufic_fifo u_rx_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.flush(rx_flush),
		.push(rx_push),
		.push_data(rx_data),
		.pop(rx_pop),
		.head_data(rx_head),
		.count_reg(rx_count)
	);

	ufic_fifo u_tx_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.flush(tx_flush),
		.push(tx_push),
		.push_data(host_wdata),
		.pop(tx_pop),
		.head_data(tx_head),
		.count_reg(tx_count)
	);

	ufic_timeout u_timeout (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.armed(fifo_en_reg && rx_count != 5'h00),
		.activity(rx_push || rx_pop),
		.divisor(div_reg),
		.line_format(lfc_reg),
		.expired_reg(timeout)
	);

	always @* begin
		case (trig_sel_reg)
			2'h0: trig_level = `UFIC_TRIG_1;
			2'h1: trig_level = `UFIC_TRIG_4;
			2'h2: trig_level = `UFIC_TRIG_8;
			default: trig_level = `UFIC_TRIG_14;
		endcase
	end

	assign rls_int = ien_reg[`UFIC_IE_RLS] && (oe_pe_fe_bi_reg != 4'h0);
	// drops below trigger or on read
	assign rda_int = ien_reg[`UFIC_IE_RDA] && (fifo_en_reg ?
		(rx_count >= trig_level) : rx_hold_full_reg);
	assign cto_int = ien_reg[`UFIC_IE_RDA] && fifo_en_reg && timeout;
	assign thre_int = ien_reg[`UFIC_IE_THRE] && thre_pend_reg;
	assign ms_int = ien_reg[`UFIC_IE_MS] && ms_pend_reg;

	always @* begin
		id_next = `UFIC_ID_NONE;
		if (rls_int) begin
			id_next = `UFIC_ID_RLS;
		end else if (rda_int) begin
			id_next = `UFIC_ID_RDA;
		end else if (cto_int) begin
			id_next = `UFIC_ID_CTO;
		end else if (thre_int) begin
			id_next = `UFIC_ID_THRE;
		end else if (ms_int) begin
			id_next = `UFIC_ID_MS;
		end
	end

	// output gated by aux output two
	assign irq = mctl_reg[`UFIC_MC_AUX2] && !iid_reg[0];
	assign irq_oe_n = !mctl_reg[`UFIC_MC_AUX2];

	// loopback feeds modem inputs from the control bits
	assign modem_now = mctl_reg[4] ? {mctl_reg[3], mctl_reg[2], mctl_reg[0],
		mctl_reg[1]} : ~modem_s2_reg;

	always @* begin
		case (host_addr)
			`UFIC_OFS_DATA: rd_mux = divisor_latch_select ? div_reg[7:0] :
				(fifo_en_reg ? rx_head : rx_hold_reg);
			`UFIC_OFS_IEN: rd_mux = divisor_latch_select ? div_reg[15:8] : ien_reg;
			// fifo mode shown in top bits
			`UFIC_OFS_IID: rd_mux = {fifo_en_reg, fifo_en_reg, 2'h0, iid_reg};
			`UFIC_OFS_LFC: rd_mux = lfc_reg;
			`UFIC_OFS_MCTL: rd_mux = mctl_reg;
			`UFIC_OFS_LSTAT: rd_mux = {1'b0, !tx_valid, !tx_full,
				oe_pe_fe_bi_reg[3], oe_pe_fe_bi_reg[2], oe_pe_fe_bi_reg[1],
				oe_pe_fe_bi_reg[0], fifo_en_reg ? rx_count != 5'h00 :
				rx_hold_full_reg};
			`UFIC_OFS_MSTAT: rd_mux = {modem_now, dmodem_reg};
			default: rd_mux = scr_reg;
		endcase
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			// pins idle high; a zero here fakes a change after reset
			modem_s1_reg <= `UFIC_PINS_IDLE;
			modem_s2_reg <= `UFIC_PINS_IDLE;
			modem_q_reg <= 4'h0;
			lfc_reg <= 8'h00;
			ien_reg <= 8'h00;
			mctl_reg <= 8'h00;
			scr_reg <= 8'h00;
			div_reg <= `UFIC_DIV_RESET;
			fifo_en_reg <= 1'b0;
			trig_sel_reg <= 2'h0;
			dma_sel_reg <= 1'b0;
			oe_pe_fe_bi_reg <= 4'h0;
			thre_pend_reg <= 1'b0;
			ms_pend_reg <= 1'b0;
			dmodem_reg <= 4'h0;
			iid_reg <= `UFIC_ID_NONE;
			rd_q_reg <= 1'b0;
			host_rdata_reg <= 8'h00;
			tx_data_reg <= 8'h00;
			rx_hold_reg <= 8'h00;
			rx_hold_full_reg <= 1'b0;
			tx_hold_reg <= 8'h00;
			tx_hold_full_reg <= 1'b0;
		end else if (ce) begin
			modem_s1_reg <= {cts_n, dsr_n, ri_n, dcd_n};
			modem_s2_reg <= modem_s1_reg;
			modem_q_reg <= modem_now;
			rd_q_reg <= host_rd;
			if (rd_start) begin
				host_rdata_reg <= rd_mux;
			end
			// code held while host reads it
			if (!iid_access) begin
				iid_reg <= id_next;
			end
			tx_data_reg <= fifo_en_reg ? tx_head : tx_hold_reg;
			if (host_wr) begin
				case (host_addr)
					`UFIC_OFS_DATA: if (divisor_latch_select) div_reg[7:0] <= host_wdata;
					`UFIC_OFS_IEN: if (divisor_latch_select) div_reg[15:8] <= host_wdata;
						else ien_reg <= {4'h0, host_wdata[3:0]};
					`UFIC_OFS_IID: begin
						fifo_en_reg <= host_wdata[`UFIC_FC_EN];
						dma_sel_reg <= host_wdata[`UFIC_FC_DMA];
						trig_sel_reg <= host_wdata[7:6];
					end
					`UFIC_OFS_LFC: lfc_reg <= host_wdata;
					`UFIC_OFS_MCTL: mctl_reg <= {3'h0, host_wdata[4:0]};
					`UFIC_OFS_SCR: scr_reg <= host_wdata;
					default: scr_reg <= scr_reg;
				endcase
			end
			// single holding bytes in non-fifo mode
			if (!fifo_en_reg && rx_valid) begin
				rx_hold_reg <= rx_data;
				rx_hold_full_reg <= 1'b1;
			end else if ((!fifo_en_reg && rd_data) || fifo_en_reg) begin
				rx_hold_full_reg <= 1'b0;
			end
			if (!fifo_en_reg && wr_data) begin
				tx_hold_reg <= host_wdata;
				tx_hold_full_reg <= 1'b1;
			end else if ((!fifo_en_reg && tx_ready) || fifo_en_reg) begin
				tx_hold_full_reg <= 1'b0;
			end
			// errors sticky until status read; new event wins
			oe_pe_fe_bi_reg <= (rd_lstat ? 4'h0 : oe_pe_fe_bi_reg) |
				{rx_valid && rx_break, rx_valid && rx_framing_err,
				rx_valid && rx_parity_err, overrun};
			// set on drain to empty, cleared by data write or by an id read showing the thre code
			if ((tx_pop && tx_count == `UFIC_ONE_BYTE) ||
				(!fifo_en_reg && tx_hold_full_reg && tx_ready)) begin
				thre_pend_reg <= 1'b1;
			end else if (wr_data || (rd_iid && iid_reg == `UFIC_ID_THRE)) begin
				thre_pend_reg <= 1'b0;
			end
			// modem change, cleared by modem status read
			dmodem_reg <= (rd_mstat ? 4'h0 : dmodem_reg) |
				(modem_now ^ modem_q_reg);
			if (modem_now != modem_q_reg) begin
				ms_pend_reg <= 1'b1;
			end else if (rd_mstat) begin
				ms_pend_reg <= 1'b0;
			end
		end
	end
endmodule

// File: ufic_top_chk.sv
// port checker for fifo control and identification
module ufic_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic ce,
	// host port
	input wire logic [2:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata_reg,
	// outputs
	input wire logic tx_valid,
	input wire logic [7:0] line_format,
	input wire logic [15:0] baud_divisor,
	input wire logic irq,
	input wire logic irq_oe_n
);
	logic rd_prev_reg;
	logic fen_reg;
	logic aux_reg;
	wire rd_go = host_rd && !rd_prev_reg && ce;
	wire wr_go = host_wr && ce;
	wire id_rd = rd_go && host_addr == 3'h2;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_prev_reg <= 1'b0;
			fen_reg <= 1'b0;
			aux_reg <= 1'b0;
		end else if (ce) begin
			rd_prev_reg <= host_rd;
			if (wr_go && host_addr == 3'h2)
				fen_reg <= host_wdata[0];
			if (wr_go && host_addr == 3'h4)
				aux_reg <= host_wdata[3];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_reset_vals:
	assert property (disable iff (1'b0) sys_rst && ce |=> !irq && irq_oe_n
		&& !tx_valid && line_format == 8'h00 && baud_divisor == 16'h0001)
		else $error("outputs not at reset values");
	chk_oe_follows:
	assert property (irq_oe_n == !aux_reg)
		else $error("irq enable does not follow aux bit");
	chk_irq_gated:
	assert property (irq_oe_n |-> !irq)
		else $error("irq high while output disabled");
	chk_fen_bits:
	assert property (id_rd |=> host_rdata_reg[7:6] == {2{$past(fen_reg)}})
		else $error("fifo enabled bits wrong");
	chk_resv_zero:
	assert property (id_rd |=> host_rdata_reg[5:4] == 2'b00)
		else $error("reserved id bits not zero");
	chk_none_code:
	assert property (id_rd && !irq_oe_n && !irq |=> host_rdata_reg[3:0] == 4'h1)
		else $error("idle id code wrong");
	chk_pend_low:
	assert property (id_rd && irq |=> !host_rdata_reg[0])
		else $error("pending bit high with irq");
	chk_id_frozen:
	assert property (host_rd && rd_prev_reg |=> $stable(host_rdata_reg))
		else $error("read data moved during access");
	chk_irq_frozen:
	assert property (host_rd && host_addr == 3'h2 && !wr_go
		|=> $stable(irq))
		else $error("shown interrupt moved during id access");
	chk_lfc_write:
	assert property (wr_go && host_addr == 3'h3 |=>
		line_format == $past(host_wdata))
		else $error("line format not written");
	chk_flush_tx:
	assert property (wr_go && host_addr == 3'h2 && fen_reg
		&& (!host_wdata[0] || host_wdata[2]) |=> !tx_valid)
		else $error("transmit data left after flush");
endmodule
bind ufic_top ufic_chk u_chk (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.ce(ce),
	.host_addr(host_addr),
	.host_rd(host_rd),
	.host_wr(host_wr),
	.host_wdata(host_wdata),
	.host_rdata_reg(host_rdata_reg),
	.tx_valid(tx_valid),
	.line_format(line_format),
	.baud_divisor(baud_divisor),
	.irq(irq),
	.irq_oe_n(irq_oe_n)
);

// File: ufic_top_tb.sv
// self-checking bench for fifo control and identification
module ufic_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] wa;
		logic [7:0] wd;
		logic [2:0] ra;
		logic [7:0] ex;
	} ufic_row_t;
	logic ref_clk, sys_rst, host_rd, host_wr, cts_n, stall, ce;
	logic tx_valid, tx_ready, rx_valid, irq, irq_oe_n;
	logic [2:0] host_addr, rx_err;
	logic [7:0] host_wdata, host_rdata_reg, tx_data_reg, rx_data, v, lf;
	logic [15:0] bd;
	int n_fail = 0;
	int n_checks = 0;
	int lvl [4] = '{1, 4, 8, 14};
	ufic_row_t rows [4] = '{'{3'h2, 8'h01, 3'h2, 8'hc1},
		'{3'h2, 8'h39, 3'h2, 8'hc1}, '{3'h2, 8'h00, 3'h2, 8'h01},
		'{3'h3, 8'h1b, 3'h3, 8'h1b}};
	ufic_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
		.host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
		.host_wdata(host_wdata), .host_rdata_reg(host_rdata_reg),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_err[0]),
		.rx_framing_err(rx_err[1]), .rx_break(rx_err[2]),
		.tx_valid(tx_valid), .tx_data_reg(tx_data_reg), .tx_ready(tx_ready),
		.cts_n(cts_n), .dsr_n(1'b1), .ri_n(1'b1), .dcd_n(1'b1),
		.line_format(lf), .baud_divisor(bd), .irq(irq), .irq_oe_n(irq_oe_n));
	ufic_far P (.ref_clk(ref_clk), .tx_valid(tx_valid),
		.tx_data_reg(tx_data_reg), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_err(rx_err), .stall(stall));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge ref_clk);
		host_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge ref_clk);
		host_rd <= 1'b0;
		@(posedge ref_clk);
		d = host_rdata_reg;
	endtask
	task automatic rc(input logic [2:0] a, input logic [7:0] e, string s);
		rd(a, v);
		chk(s, e, v);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		idle(20000);
		n_fail++;
		$display("watchdog expired");
		wrap_up;
	end
	initial begin
		sys_rst = 1'b1;
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_addr = 3'h0;
		host_wdata = 8'h00;
		cts_n = 1'b1;
		stall = 1'b0;
		ce = 1'b1;
		idle(6);
		sys_rst <= 1'b0;
		rc(3'h2, 8'h01, "reset id");
		rc(3'h3, 8'h00, "reset lfc");
		chk("reset divisor", 8'h01, bd[7:0]);
		ce <= 1'b0;
		wr(3'h7, 8'h5a);
		ce <= 1'b1;
		rc(3'h7, 8'h00, "frozen write");
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rc(rows[i].ra, rows[i].ex, "row");
		end
		chk("line format pins", 8'h1b, lf);
		$display("table test done");
		wr(3'h3, 8'h00);
		wr(3'h4, 8'h08);
		wr(3'h1, 8'h01);
		for (int t = 0; t < 4; t++) begin
			wr(3'h2, {t[1:0], 6'h07});
			repeat (lvl[t] - 1) P.send(8'h40, 3'h0);
			idle(2);
			chk("below trigger", 8'h00, {7'h0, irq});
			P.send(8'h41, 3'h0);
			idle(2);
			rc(3'h2, 8'hc4, "at trigger");
			wr(3'h2, {t[1:0], 6'h03});
			idle(2);
			chk("rx flushed", 8'h00, {7'h0, irq});
		end
		$display("trigger test done");
		wr(3'h2, 8'h07);
		wr(3'h1, 8'h05);
		P.send(8'h9e, 3'h1);
		idle(2);
		rc(3'h2, 8'hc6, "line status");
		rd(3'h5, v);
		rc(3'h2, 8'hc4, "data next");
		rc(3'h0, 8'h9e, "rx byte");
		rc(3'h2, 8'hc1, "rx read");
		$display("line status test done");
		wr(3'h1, 8'h01);
		wr(3'h2, 8'hc1);
		P.send(8'h3c, 3'h0);
		idle(400);
		chk("no early timeout", 8'h00, {7'h0, irq});
		idle(100);
		rc(3'h2, 8'hcc, "timeout");
		rc(3'h0, 8'h3c, "timeout byte");
		rc(3'h2, 8'hc1, "timeout read");
		$display("timeout test done");
		stall <= 1'b1;
		wr(3'h1, 8'h02);
		wr(3'h0, 8'h5a);
		wr(3'h0, 8'ha5);
		rc(3'h2, 8'hc1, "tx held");
		stall <= 1'b0;
		idle(12);
		chk("tx first", 8'h5a, P.cap[0]);
		chk("tx second", 8'ha5, P.cap[1]);
		chk("thre irq", 8'h01, {7'h0, irq});
		rc(3'h2, 8'hc2, "thre");
		rc(3'h2, 8'hc1, "thre read");
		stall <= 1'b1;
		wr(3'h0, 8'h11);
		wr(3'h2, 8'h05);
		idle(1);
		chk("tx flushed", 8'h00, {7'h0, tx_valid});
		stall <= 1'b0;
		$display("transmit test done");
		wr(3'h1, 8'h08);
		rd(3'h6, v);
		cts_n <= 1'b0;
		idle(5);
		rc(3'h2, 8'hc0, "modem");
		rd(3'h6, v);
		rc(3'h2, 8'hc1, "modem read");
		@(posedge ref_clk);
		host_addr <= 3'h2;
		host_rd <= 1'b1;
		cts_n <= 1'b1;
		idle(6);
		chk("id frozen", 8'h00, {7'h0, irq});
		host_rd <= 1'b0;
		idle(2);
		rc(3'h2, 8'hc0, "id released");
		wr(3'h4, 8'h00);
		idle(1);
		chk("irq off", 8'h02, {6'h0, irq_oe_n, irq});
		$display("modem test done");
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h03);
		wr(3'h1, 8'h02);
		idle(1);
		chk("divisor low", 8'h03, bd[7:0]);
		chk("divisor high", 8'h02, bd[15:8]);
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		rc(3'h2, 8'h01, "rerun reset");
		chk("rerun divisor", 8'h01, bd[7:0]);
		chk("rerun format", 8'h00, lf);
		$display("divisor and reset test done");
		wrap_up;
	end
endmodule
